// ### hdl/cfc_feature_csrs.sv
// Camera feature control register bank with tone curve and integration time logic
`timescale 1ns/100ps
module cfc_feature_csrs #(
   parameter int ADC_BITS = 10
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // Register access
   input  wire logic [11:0]         reg_addr,
   input  wire logic                reg_wr_en,
   input  wire logic                reg_rd_en,
   input  wire logic [31:0]         reg_wdata,
   output      logic [31:0]         reg_rdata_r,
   output      logic                reg_ack_r,
   // One-push adjustment engines
   input  wire logic                tone_onepush_done,
   input  wire logic                integ_onepush_done,
   output      logic                tone_onepush_r,
   output      logic                integ_onepush_r,
   // Integration time
   input  wire logic [15:0]         abs_shutter_equiv,
   input  wire logic                ae_enable,
   input  wire logic [15:0]         ae_shutter,
   input  wire logic [2:0]          frame_div_log2,
   output      logic [15:0]         shutter_now_r,
   output      logic                abs_shutter_ro_r,
   output      logic [31:0]         sensor_count_r,
   // Tone curve
   input  wire logic [11:0]         abs_tone_int,
   input  wire logic [ADC_BITS-1:0] tone_in,
   input  wire logic                tone_in_valid,
   output      logic [7:0]          tone_out_r,
   output      logic                tone_out_valid_r,
   output      logic                tone_busy_r
);

   // Refuse sizes and package layouts the fixed-width datapath cannot serve
   generate
      if (ADC_BITS < 8) begin : g_bad_adc_lo
         $error("ADC_BITS below 8 cannot feed the eight-bit linear pass");
      end
      if (ADC_BITS > 16) begin : g_bad_adc_hi
         $error("ADC_BITS above 16 overflows the log2 input");
      end
      if (cfc_pkg::HIGH_BITS + cfc_pkg::VALUE_BITS != 16) begin : g_bad_time
         $error("Shutter fields must fill 16 bits");
      end
      if (cfc_pkg::VALUE_LSB + cfc_pkg::VALUE_BITS > cfc_pkg::HIGH_LSB) begin : g_bad_value
         $error("Value field runs into the high field");
      end
      if (cfc_pkg::HIGH_LSB + 12 > cfc_pkg::BIT_AUTO) begin : g_bad_high
         $error("High field runs into the control bits");
      end
      if (cfc_pkg::QUO_BITS != 22 || cfc_pkg::LOG_FRAC != 8) begin : g_bad_quo
         $error("Divider state is sized for 22 quotient bits");
      end
      if (cfc_pkg::GAMMA_SHIFT + 12 > cfc_pkg::QUO_BITS) begin : g_bad_shift
         $error("Scaled log difference overflows the dividend");
      end
   endgenerate

   // Fixed point log2 with LOG_FRAC fraction bits; mantissa taken as linear
   function automatic logic [11:0] log2fx(input logic [15:0] v);
      logic [3:0]  e;
      logic [15:0] sh;
      e = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (v[i]) begin
            e = 4'(i);
         end
      end
      sh     = v << (4'hF - e);
      log2fx = {e, sh[14:7]};
   endfunction : log2fx

   // Whole feature word from its fields; reserved bits stay zero
   function automatic logic [31:0] pack_feat(
      input logic        present,
      input logic        absc,
      input logic        op,
      input logic        onb,
      input logic        am,
      input logic [11:0] hi,
      input logic [11:0] val
   );
      logic [31:0] w;
      w                          = 32'h0000_0000;
      w[cfc_pkg::BIT_PRESENT]    = present;
      w[cfc_pkg::BIT_ABS]        = absc;
      w[cfc_pkg::BIT_ONEPUSH]    = op;
      w[cfc_pkg::BIT_ON]         = onb;
      w[cfc_pkg::BIT_AUTO]       = am;
      w[cfc_pkg::HIGH_LSB +: 12] = hi;
      w[cfc_pkg::VALUE_LSB +: 12] = val;
      pack_feat                  = w;
   endfunction : pack_feat

   localparam logic [15:0] ADC_FULL = 16'((32'h1 << ADC_BITS) - 1);
   localparam logic [11:0] LOG_Z    = log2fx(ADC_FULL);

   logic        wr_tone;
   logic        wr_integ;
   logic        tone_abs;
   logic        tone_on;
   logic        tone_auto;
   logic [11:0] tone_value;
   logic        integ_abs;
   logic        integ_on;
   logic        integ_auto;
   logic [3:0]  integ_high;
   logic [11:0] integ_value;
   logic        manual_abs;
   logic [15:0] shutter_src;
   logic [11:0] gamma_int;
   logic [15:0] tone_x;
   logic [11:0] log_x;
   logic [11:0] log_d;
   logic [47:0] count_prod;
   logic [47:0] count_quo;
   logic [47:0] count_full;
   logic [31:0] tone_word;
   logic [31:0] integ_word;
   logic [13:0] q_int;
   logic [7:0]  q_frac;
   logic [17:0] tone_prod;
   logic [12:0] rem_try;

   cfc_pkg::cfc_top_s st_r;
   cfc_pkg::cfc_top_s st_nxt;

   // Only the two implemented features take writes
   assign wr_tone  = reg_wr_en && (reg_addr == cfc_pkg::OFS_TONE);
   assign wr_integ = reg_wr_en && (reg_addr == cfc_pkg::OFS_INTEG);

   cfc_feature_reg #(
      .ALWAYS_ON (1'b0),
      .HAS_HIGH  (1'b0),
      .ON_RST    (cfc_pkg::TONE_ON_RST),
      .VALUE_RST (cfc_pkg::TONE_VALUE_RST)
   ) u_tone (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .wr_en        (wr_tone),
      .wdata        (reg_wdata),
      .value_lock   (1'b0),
      .onepush_done (tone_onepush_done),
      .abs_ctrl     (tone_abs),
      .onepush      (tone_onepush_r),
      .on           (tone_on),
      .auto_mode    (tone_auto),
      .high         (),
      .value        (tone_value)
   );

   // Value field locks in manual absolute state
   cfc_feature_reg #(
      .ALWAYS_ON (1'b1),
      .HAS_HIGH  (1'b1),
      .ON_RST    (1'b1),
      .VALUE_RST (cfc_pkg::INTEG_VALUE_RST)
   ) u_integ (
      .clock        (clock),
      .sys_rst      (sys_rst),
      .wr_en        (wr_integ),
      .wdata        (reg_wdata),
      .value_lock   (manual_abs),
      .onepush_done (integ_onepush_done),
      .abs_ctrl     (integ_abs),
      .onepush      (integ_onepush_r),
      .on           (integ_on),
      .auto_mode    (integ_auto),
      .high         (integ_high),
      .value        (integ_value)
   );

   assign manual_abs = integ_abs && !integ_auto;

   // Current integration time by control state
   always_comb begin
      if (integ_auto) begin
         // Controller time, or the last time held while the controller is off
         shutter_src = ae_enable ? ae_shutter : st_r.shutter_now;
      end else if (integ_abs) begin
         // Converted absolute register; the value field only mirrors it
         shutter_src = abs_shutter_equiv;
      end else begin
         // Host-written high nibble and value field
         shutter_src = {integ_high, integ_value};
      end
   end

   // Absolute tone setting overrides the value field
   assign gamma_int = tone_abs ? abs_tone_int : tone_value;

   // Read images of the two implemented features
   assign tone_word  = pack_feat(1'b1, tone_abs, tone_onepush_r, tone_on, tone_auto,
                                 12'h000, tone_value);
   assign integ_word = pack_feat(1'b1, integ_abs, integ_onepush_r, integ_on, integ_auto,
                                 {8'h00, shutter_src[15:12]}, shutter_src[11:0]);

   assign tone_x     = 16'(tone_in);
   assign log_x      = log2fx(tone_x);
   assign log_d      = LOG_Z - log_x;
   assign count_prod = 48'(st_r.shutter_now) * 48'(cfc_pkg::PIX_CLK_HZ);
   assign count_quo  = count_prod / 48'(cfc_pkg::SENSOR_DIV);
   // Slower frame rate gives a longer integration: scale by the divider
   assign count_full = count_quo << frame_div_log2;
   assign q_int      = st_r.quo[21:cfc_pkg::LOG_FRAC];
   assign q_frac     = st_r.quo[cfc_pkg::LOG_FRAC-1:0];
   // 2^-q is taken as (2 - frac) / 2^(int+1), a linear mantissa trade for area
   assign tone_prod  = 18'(cfc_pkg::TONE_FULL) * (18'h0_0200 - 18'(q_frac));
   assign rem_try    = {st_r.rem[11:0], st_r.dividend[21]};

   always_comb begin
      st_nxt            = st_r;
      st_nxt.ack        = reg_rd_en || reg_wr_en;
      st_nxt.tone_valid = 1'b0;
      st_nxt.abs_ro     = !manual_abs;
      st_nxt.shutter_now = shutter_src;
      st_nxt.sensor_count = count_full[31:0];

      if (reg_rd_en) begin
         unique case (reg_addr)
            cfc_pkg::OFS_TONE: begin
               st_nxt.rdata = tone_word;
            end
            cfc_pkg::OFS_INTEG: begin
               st_nxt.rdata = integ_word;
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end

      unique case (st_r.tone_st)
         cfc_pkg::CFC_TONE_IDLE: begin
            if (tone_in_valid) begin
               if (!tone_on) begin
                  // Feature off: linear pass of the top eight bits
                  st_nxt.tone_out   = tone_in[ADC_BITS-1 -: 8];
                  st_nxt.tone_valid = 1'b1;
               end else if (tone_x == 16'h0000) begin
                  st_nxt.tone_out   = 8'h00;
                  st_nxt.tone_valid = 1'b1;
               end else if (gamma_int == 12'h000) begin
                  st_nxt.tone_out   = cfc_pkg::TONE_FULL[7:0];
                  st_nxt.tone_valid = 1'b1;
               end else begin
                  st_nxt.dividend = 22'(log_d) << cfc_pkg::GAMMA_SHIFT;
                  st_nxt.divisor  = gamma_int;
                  st_nxt.rem      = 13'h0000;
                  st_nxt.quo      = 22'h00_0000;
                  st_nxt.div_cnt  = 5'(cfc_pkg::QUO_BITS - 1);
                  st_nxt.tone_st  = cfc_pkg::CFC_TONE_DIV;
               end
            end
         end
         cfc_pkg::CFC_TONE_DIV: begin
            // Restoring divide, one quotient bit per cycle
            st_nxt.dividend = {st_r.dividend[20:0], 1'b0};
            if (rem_try >= {1'b0, st_r.divisor}) begin
               st_nxt.rem = rem_try - {1'b0, st_r.divisor};
               st_nxt.quo = {st_r.quo[20:0], 1'b1};
            end else begin
               st_nxt.rem = rem_try;
               st_nxt.quo = {st_r.quo[20:0], 1'b0};
            end
            if (st_r.div_cnt == 5'h00) begin
               st_nxt.tone_st = cfc_pkg::CFC_TONE_OUT;
            end else begin
               st_nxt.div_cnt = st_r.div_cnt - 5'h01;
            end
         end
         cfc_pkg::CFC_TONE_OUT: begin
            if (q_int >= 14'h0008) begin
               st_nxt.tone_out = 8'h00;
            end else begin
               st_nxt.tone_out = 8'(tone_prod >> (5'd9 + 5'(q_int)));
            end
            st_nxt.tone_valid = 1'b1;
            st_nxt.tone_st    = cfc_pkg::CFC_TONE_IDLE;
         end
         default: begin
            st_nxt.tone_st = cfc_pkg::CFC_TONE_IDLE;
         end
      endcase
      // Registered so the busy port needs no decode after the flop
      st_nxt.tone_busy = (st_nxt.tone_st != cfc_pkg::CFC_TONE_IDLE);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r.rdata        <= 32'h0000_0000;
         st_r.ack          <= 1'b0;
         st_r.shutter_now  <= {4'h0, cfc_pkg::INTEG_VALUE_RST};
         st_r.abs_ro       <= 1'b1;
         st_r.sensor_count <= 32'h0000_0000;
         st_r.tone_st      <= cfc_pkg::CFC_TONE_IDLE;
         st_r.div_cnt      <= 5'h00;
         st_r.rem          <= 13'h0000;
         st_r.dividend     <= 22'h00_0000;
         st_r.quo          <= 22'h00_0000;
         st_r.divisor      <= 12'h000;
         st_r.tone_out     <= 8'h00;
         st_r.tone_valid   <= 1'b0;
         st_r.tone_busy    <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_r      = st_r.rdata;
   assign reg_ack_r        = st_r.ack;
   assign shutter_now_r    = st_r.shutter_now;
   assign abs_shutter_ro_r = st_r.abs_ro;
   assign sensor_count_r   = st_r.sensor_count;
   assign tone_out_r       = st_r.tone_out;
   assign tone_out_valid_r = st_r.tone_valid;
   assign tone_busy_r      = st_r.tone_busy;

endmodule : cfc_feature_csrs

// ### hdl/cfc_feature_reg.sv
// One feature control register: write gating, one-push flag and stored fields
`timescale 1ns/100ps
module cfc_feature_reg #(
   parameter bit          ALWAYS_ON = 1'b0,
   parameter bit          HAS_HIGH  = 1'b0,
   parameter bit          ON_RST    = 1'b1,
   parameter logic [11:0] VALUE_RST = 12'h0000
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Register write
   input  wire logic        wr_en,
   input  wire logic [31:0] wdata,
   input  wire logic        value_lock,
   // Automatic adjustment
   input  wire logic        onepush_done,
   // Stored fields
   output      logic        abs_ctrl,
   output      logic        onepush,
   output      logic        on,
   output      logic        auto_mode,
   output      logic [3:0]  high,
   output      logic [11:0] value
);

   cfc_pkg::cfc_feat_s st_r;
   cfc_pkg::cfc_feat_s st_nxt;
   logic               wr_ok;

   always_comb begin
      st_nxt = st_r;
      wr_ok  = wr_en && (st_r.on || ALWAYS_ON);
      if (onepush_done) begin
         st_nxt.onepush = 1'b0;
      end
      if (wr_ok) begin
         st_nxt.abs_ctrl  = wdata[cfc_pkg::BIT_ABS];
         st_nxt.auto_mode = wdata[cfc_pkg::BIT_AUTO];
         // Set wins over a completion in the same cycle
         if (!st_r.auto_mode && wdata[cfc_pkg::BIT_ONEPUSH]) begin
            st_nxt.onepush = 1'b1;
         end
         if (!st_r.auto_mode && !value_lock) begin
            st_nxt.value = wdata[cfc_pkg::VALUE_LSB +: cfc_pkg::VALUE_BITS];
            if (HAS_HIGH) begin
               st_nxt.high = wdata[cfc_pkg::HIGH_LSB +: cfc_pkg::HIGH_BITS];
            end
         end
      end
      if (wr_en && !ALWAYS_ON) begin
         st_nxt.on = wdata[cfc_pkg::BIT_ON];
      end
      if (ALWAYS_ON) begin
         st_nxt.on = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r.abs_ctrl  <= 1'b0;
         st_r.onepush   <= 1'b0;
         st_r.on        <= ALWAYS_ON | ON_RST;
         st_r.auto_mode <= 1'b0;
         st_r.high      <= 4'h0;
         st_r.value     <= VALUE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign abs_ctrl  = st_r.abs_ctrl;
   assign onepush   = st_r.onepush;
   assign on        = st_r.on;
   assign auto_mode = st_r.auto_mode;
   assign high      = st_r.high;
   assign value     = st_r.value;

endmodule : cfc_feature_reg

// ### hdl/cfc_pkg.sv
// Package: offsets, field layout, reset values, timing and state types of the feature CSRs
package cfc_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_TINT    = 12'h0810;
   localparam logic [11:0] OFS_COLOUR  = 12'h0814;
   localparam logic [11:0] OFS_TONE    = 12'h0818;
   localparam logic [11:0] OFS_INTEG   = 12'h081C;

   // Field positions (bit 0 of the map is the word MSB)
   localparam int          BIT_PRESENT = 31;
   localparam int          BIT_ABS     = 30;
   localparam int          BIT_ONEPUSH = 26;
   localparam int          BIT_ON      = 25;
   localparam int          BIT_AUTO    = 24;
   localparam int          HIGH_LSB    = 12;
   localparam int          HIGH_BITS   = 4;
   localparam int          VALUE_LSB   = 0;
   localparam int          VALUE_BITS  = 12;

   // Reset values
   localparam logic [11:0] TONE_VALUE_RST  = 12'h0400;
   localparam logic [11:0] INTEG_VALUE_RST = 12'h0100;
   localparam logic        TONE_ON_RST     = 1'b1;

   // Conversion constants
   localparam longint      PIX_CLK_HZ  = 40_000_000;
   localparam longint      SENSOR_DIV  = 27_000;
   localparam int          GAMMA_SHIFT = 10;
   localparam logic [8:0]  TONE_FULL   = 9'h0FF;
   localparam int          LOG_FRAC    = 8;
   localparam int          QUO_BITS    = 22;

   typedef enum logic [1:0] {
      CFC_TONE_IDLE = 2'b00,
      CFC_TONE_DIV  = 2'b01,
      CFC_TONE_OUT  = 2'b10
   } cfc_tone_e;

   typedef struct packed {
      logic        abs_ctrl;
      logic        onepush;
      logic        on;
      logic        auto_mode;
      logic [3:0]  high;
      logic [11:0] value;
   } cfc_feat_s;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ack;
      logic [15:0] shutter_now;
      logic        abs_ro;
      logic [31:0] sensor_count;
      cfc_tone_e   tone_st;
      logic [4:0]  div_cnt;
      logic [12:0] rem;
      logic [21:0] dividend;
      logic [21:0] quo;
      logic [11:0] divisor;
      logic [7:0]  tone_out;
      logic        tone_valid;
      logic        tone_busy;
   } cfc_top_s;

endpackage : cfc_pkg

// ### tb/cfc_feature_csrs_chk.sv
// Checker for the feature control register bank ports
`timescale 1ns/100ps
module cfc_feature_csrs_chk (
   // Clock and reset
   input wire logic        clock,
   input wire logic        sys_rst,
   // Register access
   input wire logic [11:0] reg_addr,
   input wire logic        reg_wr_en,
   input wire logic        reg_rd_en,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata_r,
   input wire logic        reg_ack_r,
   // One-push and integration time
   input wire logic        tone_onepush_r,
   input wire logic        integ_onepush_done,
   input wire logic        integ_onepush_r,
   input wire logic [2:0]  frame_div_log2,
   input wire logic [15:0] shutter_now_r,
   input wire logic [31:0] sensor_count_r,
   // Tone curve
   input wire logic        tone_busy_r,
   input wire logic        tone_out_valid_r
);
   logic [31:0] cnt_exp_r;
   logic        seen_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // Same one-edge lag as the count itself
   always_ff @(posedge clock) begin
      cnt_exp_r <= 32'((64'(shutter_now_r) * cfc_pkg::PIX_CLK_HZ / cfc_pkg::SENSOR_DIV)
                       << frame_div_log2);
      seen_r    <= !sys_rst;
   end

   property p_ack; reg_ack_r == $past(reg_rd_en || reg_wr_en); endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle after strobe");
   property p_absent; reg_rd_en && (reg_addr == cfc_pkg::OFS_TINT ||
      reg_addr == cfc_pkg::OFS_COLOUR) |=> reg_rdata_r == 32'h0000_0000; endproperty
   a_absent: assert property (p_absent) else $error("absent feature reads nonzero");
   property p_integ_on; reg_rd_en && reg_addr == cfc_pkg::OFS_INTEG |=>
      reg_rdata_r[31] && reg_rdata_r[25]; endproperty
   a_integ_on: assert property (p_integ_on) else $error("integration presence or on low");
   property p_tone_pres; reg_rd_en && reg_addr == cfc_pkg::OFS_TONE |=> reg_rdata_r[31]; endproperty
   a_tone_pres: assert property (p_tone_pres) else $error("tone presence low");
   property p_resv; reg_rd_en |=> reg_rdata_r[29:27] == 3'b000; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits nonzero");
   property p_op_read; reg_rd_en && reg_addr == cfc_pkg::OFS_TONE |=>
      reg_rdata_r[26] == $past(tone_onepush_r); endproperty
   a_op_read: assert property (p_op_read) else $error("one-push read mismatch");
   property p_op_set; $rose(tone_onepush_r) |->
      $past(reg_wr_en && reg_addr == cfc_pkg::OFS_TONE && reg_wdata[26]); endproperty
   a_op_set: assert property (p_op_set) else $error("one-push set without write");
   property p_op_clr; integ_onepush_done && !(reg_wr_en && reg_wdata[26] &&
      reg_addr == cfc_pkg::OFS_INTEG) |=> !integ_onepush_r; endproperty
   a_op_clr: assert property (p_op_clr) else $error("one-push not cleared");
   property p_tone_lat; $rose(tone_busy_r) |-> ##23 tone_out_valid_r; endproperty
   a_tone_lat: assert property (p_tone_lat) else $error("tone result late");
   property p_cnt; seen_r |-> sensor_count_r == cnt_exp_r; endproperty
   a_cnt: assert property (p_cnt) else $error("sensor count wrong");
endmodule : cfc_feature_csrs_chk

bind cfc_feature_csrs cfc_feature_csrs_chk u_chk (
   .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
   .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
   .reg_ack_r(reg_ack_r), .tone_onepush_r(tone_onepush_r),
   .integ_onepush_done(integ_onepush_done), .integ_onepush_r(integ_onepush_r),
   .frame_div_log2(frame_div_log2), .shutter_now_r(shutter_now_r),
   .sensor_count_r(sensor_count_r), .tone_busy_r(tone_busy_r),
   .tone_out_valid_r(tone_out_valid_r));

// ### tb/tb_cfc_feature_csrs.sv
// Self-checking bench for the feature control register bank
`timescale 1ns/100ps
module tb_cfc_feature_csrs;
   logic        clock, sys_rst, reg_wr_en, reg_rd_en, reg_ack_r, ae_enable;
   logic        tone_onepush_done, integ_onepush_done, tone_onepush_r, integ_onepush_r;
   logic        abs_shutter_ro_r, tone_in_valid, tone_out_valid_r, tone_busy_r;
   logic [11:0] reg_addr, abs_tone_int, v, a;
   logic [31:0] reg_wdata, reg_rdata_r, sensor_count_r, rd_q, w;
   logic [15:0] abs_shutter_equiv, ae_shutter, shutter_now_r, r16;
   logic [2:0]  frame_div_log2;
   logic [9:0]  tone_in;
   logic [7:0]  tone_out_r;
   integer      seed;
   int          error_cnt, cmp_count;

   cfc_feature_csrs #(.ADC_BITS(10)) u_cfc_feature_csrs (
      .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
      .reg_ack_r(reg_ack_r), .tone_onepush_done(tone_onepush_done),
      .integ_onepush_done(integ_onepush_done), .tone_onepush_r(tone_onepush_r),
      .integ_onepush_r(integ_onepush_r), .abs_shutter_equiv(abs_shutter_equiv),
      .ae_enable(ae_enable), .ae_shutter(ae_shutter), .frame_div_log2(frame_div_log2),
      .shutter_now_r(shutter_now_r), .abs_shutter_ro_r(abs_shutter_ro_r),
      .sensor_count_r(sensor_count_r), .abs_tone_int(abs_tone_int), .tone_in(tone_in),
      .tone_in_valid(tone_in_valid), .tone_out_r(tone_out_r),
      .tone_out_valid_r(tone_out_valid_r), .tone_busy_r(tone_busy_r));

   always #5 clock = ~clock;

   // Divider kept at 16 or less so the count never wraps
   always @(negedge clock) frame_div_log2 <= 3'($unsigned($random(seed)) % 5);

   function automatic logic [31:0] fword(input logic ab, op, on, am,
                                         input logic [3:0] hi, input logic [11:0] val);
      return {1'b1, ab, 3'b000, op, on, am, 8'h00, hi, val};
   endfunction : fword

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic print_verdict;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic acc(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(negedge clock);
      reg_addr = ad;
      reg_wdata = d;
      reg_wr_en = wr;
      reg_rd_en = !wr;
      @(negedge clock);
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      chk({31'h0, reg_ack_r}, 32'h1, "ack");
      rd_q = reg_rdata_r;
   endtask : acc

   task automatic rdc(input logic [11:0] ad, input logic [31:0] exp, input string msg);
      acc(1'b0, ad, 32'h0);
      chk(rd_q, exp, msg);
   endtask : rdc

   task automatic tone(input logic [9:0] x, input logic [7:0] exp);
      int n;
      @(negedge clock);
      tone_in = x;
      tone_in_valid = 1'b1;
      @(negedge clock);
      tone_in_valid = 1'b0;
      n = 0;
      while (tone_out_valid_r !== 1'b1 && n < 40) begin
         @(negedge clock);
         n++;
      end
      if (n >= 40) begin
         error_cnt++;
         $display("ERROR %0t tone result never came", $time);
         print_verdict();
      end else begin
         chk({24'h0, tone_out_r}, {24'h0, exp}, "tone out");
      end
   endtask : tone

   initial begin
      seed = 78;
      error_cnt = 0;
      cmp_count = 0;
      clock = 1'b0;
      sys_rst = 1'b1;
      {reg_wr_en, reg_rd_en, tone_onepush_done, integ_onepush_done} = 4'h0;
      {ae_enable, tone_in_valid, reg_addr, reg_wdata, tone_in} = '0;
      {abs_shutter_equiv, ae_shutter, abs_tone_int} = '0;
      repeat (4) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      rdc(cfc_pkg::OFS_TINT, 32'h0, "tint reset");
      rdc(cfc_pkg::OFS_COLOUR, 32'h0, "colour reset");
      rdc(cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h400), "tone reset");
      rdc(cfc_pkg::OFS_INTEG, fword(0, 0, 1, 0, 4'h0, 12'h100), "integ reset");
      rdc(12'h820, 32'h0, "unmapped");
      acc(1'b1, cfc_pkg::OFS_TINT, 32'hFFFF_FFFF);
      acc(1'b1, cfc_pkg::OFS_COLOUR, 32'hFFFF_FFFF);
      rdc(cfc_pkg::OFS_TINT, 32'h0, "tint write");
      rdc(cfc_pkg::OFS_COLOUR, 32'h0, "colour write");
      repeat (8) begin
         w = $random(seed);
         w[26:24] = 3'b010;
         acc(1'b1, cfc_pkg::OFS_TONE, w);
         rdc(cfc_pkg::OFS_TONE, fword(w[30], 0, 1, 0, 4'h0, w[11:0]), "tone rw");
      end
      // Mode bit lands first; gating follows the state before a write
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 0, 1, 1, 4'h0, 12'h400));
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 1, 1, 1, 4'h0, 12'h123));
      chk({31'h0, tone_onepush_r}, 32'h0, "one-push in auto");
      rdc(cfc_pkg::OFS_TONE, fword(0, 0, 1, 1, 4'h0, 12'h400), "auto value");
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h3FF));
      rdc(cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h400), "leave auto");
      for (int i = 0; i < 2; i++) begin
         a = i ? cfc_pkg::OFS_INTEG : cfc_pkg::OFS_TONE;
         v = i ? 12'h100 : 12'h400;
         acc(1'b1, a, fword(0, 1, 1, 0, 4'h0, v));
         chk({31'h0, i ? integ_onepush_r : tone_onepush_r}, 32'h1, "one-push run");
         rdc(a, fword(0, 1, 1, 0, 4'h0, v), "one-push read");
         tone_onepush_done = (i == 0);
         integ_onepush_done = (i == 1);
         @(negedge clock);
         {tone_onepush_done, integ_onepush_done} = 2'b00;
         rdc(a, fword(0, 0, 1, 0, 4'h0, v), "one-push done");
      end
      tone(10'h3FF, 8'hFF);
      tone(10'h1FF, 8'h7F);
      tone(10'h000, 8'h00);
      acc(1'b1, cfc_pkg::OFS_TONE, fword(1, 0, 1, 0, 4'h0, 12'h400));
      tone(10'h155, 8'hFF);
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h000));
      tone(10'h155, 8'hFF);
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 0, 0, 0, 4'h0, 12'h400));
      repeat (3) begin
         tone_in = 10'($random(seed));
         tone(tone_in, tone_in[9:2]);
      end
      acc(1'b1, cfc_pkg::OFS_TONE, fword(1, 1, 0, 1, 4'h0, 12'h055));
      rdc(cfc_pkg::OFS_TONE, fword(0, 0, 0, 0, 4'h0, 12'h400), "off locks");
      acc(1'b1, cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h077));
      rdc(cfc_pkg::OFS_TONE, fword(0, 0, 1, 0, 4'h0, 12'h400), "on only");
      acc(1'b1, cfc_pkg::OFS_INTEG, fword(0, 0, 0, 0, 4'hA, 12'h5C3));
      rdc(cfc_pkg::OFS_INTEG, fword(0, 0, 1, 0, 4'hA, 12'h5C3), "integ manual");
      chk({16'h0, shutter_now_r}, 32'h0000_A5C3, "manual time");
      chk({31'h0, abs_shutter_ro_r}, 32'h1, "abs ro manual");
      abs_shutter_equiv = 16'($random(seed));
      acc(1'b1, cfc_pkg::OFS_INTEG, fword(1, 0, 1, 0, 4'h0, 12'h000));
      acc(1'b1, cfc_pkg::OFS_INTEG, fword(1, 0, 1, 0, 4'h1, 12'h111));
      r16 = abs_shutter_equiv;
      rdc(cfc_pkg::OFS_INTEG, fword(1, 0, 1, 0, r16[15:12], r16[11:0]), "abs value");
      chk({31'h0, abs_shutter_ro_r}, 32'h0, "abs writable");
      ae_enable = 1'b1;
      ae_shutter = 16'($random(seed));
      r16 = ae_shutter;
      acc(1'b1, cfc_pkg::OFS_INTEG, fword(0, 0, 1, 1, 4'h0, 12'h000));
      rdc(cfc_pkg::OFS_INTEG, fword(0, 0, 1, 1, r16[15:12], r16[11:0]), "auto time");
      chk({16'h0, shutter_now_r}, {16'h0, r16}, "auto shutter");
      chk({31'h0, abs_shutter_ro_r}, 32'h1, "abs ro auto");
      ae_enable = 1'b0;
      ae_shutter = ~r16;
      repeat (3) @(negedge clock);
      chk({16'h0, shutter_now_r}, {16'h0, r16}, "auto hold");
      print_verdict();
   end
endmodule : tb_cfc_feature_csrs
